// ===== design/dtd_decoder.v
// Control tag decoder with AHB-Lite status and control registers
// Summary of operation
// - While command tag is high, the ten bus bits select the drive actions.
// - Bit 0 enables the write driver unless the drive is not writable.
// - Bit 1 enables reading; its leading edge starts all-zeros sync.
// - Read enable is refused while seek error or fault is present.
// - Bit 2 offsets the actuator inward, toward the spindle, if supported.
// - Bit 3 offsets the actuator outward, away from the spindle, if supported.
// - After either offset, track_settled stays low for 2.75 ms.
// - Bit 4 pulse clears the fault latch only once the fault cause is gone.
// - Bit 5 with write enable writes an address mark.
// - Bit 5 with read enable starts an address mark search.
// - Bit 6 pulse returns the head positioner to track zero.
// - Home seek also resets head address, difference counter and seek error.
// - Bits 7 and 8 make the data separator strobe early or late.
// - On dual-channel units bit 9 clears reserve and priority reserve.
// - Without drive_pick every command is ignored; of the drive outputs only fault and seek_error can still rise.
// - Bus lines carry controller data whose meaning depends on the tag.
// - A latched fault disables the write circuitry at once.
`timescale 1ns/100ps
`include "dtd_regs.vh"
module dtd_decoder #(
    parameter SETTLE_CYCLES = `DTD_SETTLE_CYCLES
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        drive_pick,
    input  wire        cmd_tag,
    input  wire [9:0]  bus_bits,
    input  wire        fault_cause,
    input  wire        seek_err_set,
    input  wire        channel_reserved_in,
    input  wire        priority_reserved_in,
    output reg         write_enable,
    output reg         read_enable,
    output reg         read_sync_start,
    output reg         offset_in,
    output reg         offset_out,
    output reg         track_settled,
    output reg         fault,
    output reg         seek_error,
    output reg         amark_write,
    output reg         amark_search,
    output reg         home_seek,
    output reg         home_reset,
    output reg         strobe_early,
    output reg         strobe_late,
    output reg         release_reserve,
    output reg         channel_reserved,
    output reg         priority_reserved
);
    // Synchronised cable inputs
    wire [11:0] sync_vec;
    wire [9:0]  s_bits;
    wire        s_tag;
    wire        s_pick;
    dtd_sync #(
        .W (12)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pin_in   ({drive_pick, cmd_tag, bus_bits}),
        .sync_out (sync_vec)
    );
    assign s_bits = sync_vec[9:0];
    assign s_tag  = sync_vec[10];
    assign s_pick = sync_vec[11];

    // Software control and drive-state registers
    reg  [31:0] ctrl;
    reg  [31:0] cond;
    reg  [31:0] event_cnt;
    wire        ofs_supported = ctrl[`DTD_CTRL_OFFSET_EN];
    wire        dual_channel  = ctrl[`DTD_CTRL_DUAL_EN];
    wire        fault_now     = cond[`DTD_COND_FAULT] | fault_cause;
    wire        write_prot    = cond[`DTD_COND_WPROT];

    // Command decode, only under tag while picked
    wire        active = s_pick & s_tag;
    wire [9:0]  cmd    = active ? s_bits : 10'h000;
    reg         tag_q;
    wire        tag_rise = active & ~tag_q;
    reg         read_q;

    wire next_write = cmd[`DTD_BIT_WRITE] & ~write_prot & ~fault;
    wire next_read  = cmd[`DTD_BIT_READ] & ~seek_error & ~fault;
    wire next_oin   = cmd[`DTD_BIT_OFS_IN] & ofs_supported;
    wire next_oout  = cmd[`DTD_BIT_OFS_OUT] & ofs_supported & ~cmd[`DTD_BIT_OFS_IN];
    wire ofs_start  = (next_oin & ~offset_in) | (next_oout & ~offset_out);
    wire next_fclr  = tag_rise & s_bits[`DTD_BIT_FCLR];
    wire next_home  = tag_rise & s_bits[`DTD_BIT_HOME];
    wire next_rel   = tag_rise & s_bits[`DTD_BIT_RELEASE] & dual_channel;
    wire settle_busy;

    dtd_settle #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (ofs_start),
        .busy    (settle_busy)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tag_q             <= 1'b0;
            read_q            <= 1'b0;
            write_enable      <= 1'b0;
            read_enable       <= 1'b0;
            read_sync_start   <= 1'b0;
            offset_in         <= 1'b0;
            offset_out        <= 1'b0;
            track_settled     <= 1'b0;
            fault             <= 1'b0;
            seek_error        <= 1'b0;
            amark_write       <= 1'b0;
            amark_search      <= 1'b0;
            home_seek         <= 1'b0;
            home_reset        <= 1'b0;
            strobe_early      <= 1'b0;
            strobe_late       <= 1'b0;
            release_reserve   <= 1'b0;
            channel_reserved  <= 1'b0;
            priority_reserved <= 1'b0;
        end else begin
            tag_q           <= active;
            read_q          <= next_read;
            write_enable    <= next_write & ~fault_now;
            read_enable     <= next_read;
            read_sync_start <= next_read & ~read_q;
            offset_in       <= next_oin;
            offset_out      <= next_oout;
            track_settled   <= s_pick & ~settle_busy & ~ofs_start;
            // Fault latch: new cause wins over a clear
            if (fault_now)
                fault <= 1'b1;
            else if (next_fclr)
                fault <= 1'b0;
            // Seek error: new error wins over home seek
            if (seek_err_set)
                seek_error <= 1'b1;
            else if (next_home)
                seek_error <= 1'b0;
            amark_write     <= cmd[`DTD_BIT_AMARK] & next_write;
            amark_search    <= cmd[`DTD_BIT_AMARK] & next_read;
            home_seek       <= next_home;
            home_reset      <= next_home;
            strobe_early    <= cmd[`DTD_BIT_EARLY] & ~cmd[`DTD_BIT_LATE];
            strobe_late     <= cmd[`DTD_BIT_LATE] & ~cmd[`DTD_BIT_EARLY];
            release_reserve <= next_rel;
            channel_reserved  <= s_pick & channel_reserved_in & ~next_rel;
            priority_reserved <= s_pick & priority_reserved_in & ~next_rel;
        end
    end

    // AHB-Lite slave, zero wait states
    reg        dp_write;
    reg        dp_valid;
    reg [11:0] dp_addr;
    wire       ap_valid = hsel & htrans[1] & hready;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write  <= 1'b0;
            dp_valid  <= 1'b0;
            dp_addr   <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                dp_valid <= ap_valid;
                dp_write <= ap_valid & hwrite;
                dp_addr  <= haddr[11:0];
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl      <= `DTD_CTRL_RESET;
            cond      <= `DTD_COND_RESET;
            event_cnt <= 32'h0000_0000;
        end else begin
            if (dp_write && dp_addr == `DTD_ADDR_CTRL)
                ctrl <= {30'h0000_0000, hwdata[1:0]};
            if (dp_write && dp_addr == `DTD_ADDR_COND)
                cond <= {29'h0000_0000, hwdata[2:0]};
            if (dp_write && dp_addr == `DTD_ADDR_EVENT)
                event_cnt <= 32'h0000_0000;
            else if (tag_rise)
                event_cnt <= event_cnt + 32'h0000_0001;
        end
    end

    // Read data is registered in the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_valid && !hwrite) begin
            case (haddr[11:0])
                `DTD_ADDR_CTRL:   hrdata <= ctrl;
                `DTD_ADDR_COND:   hrdata <= {29'h0000_0000, write_prot, seek_error, fault};
                `DTD_ADDR_ACTION: hrdata <= {15'h0000, priority_reserved, channel_reserved, track_settled,
                                             strobe_late, strobe_early, home_seek, amark_search, amark_write,
                                             offset_out, offset_in, read_enable, write_enable, s_pick,
                                             s_tag, active, cmd[9:0] == 10'h000, tag_q};
                `DTD_ADDR_EVENT:  hrdata <= event_cnt;
                default:          hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== design/dtd_settle.v
// Settle timer that holds track_settled low after a head offset command
`timescale 1ns/100ps
module dtd_settle #(
    parameter CYCLES = 275000
) (
    input  wire hclk,
    input  wire hresetn,
    input  wire start,
    output wire busy
);
    reg [19:0] count;
    assign busy = (count != 20'h0_0000);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            count <= 20'h0_0000;
        else if (start)
            count <= CYCLES[19:0];
        else if (busy)
            count <= count - 20'h0_0001;
    end
endmodule

// ===== design/dtd_sync.v
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module dtd_sync #(
    parameter W = 1
) (
    input  wire         hclk,
    input  wire         hresetn,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1[i]       <= 1'b0;
                    s2[i]       <= 1'b0;
                    s3[i]       <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    s1[i] <= pin_in[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i])
                        sync_out[i] <= s3[i];
                end
            end
        end
    endgenerate
endmodule

// ===== pkg/dtd_regs.vh
// Register map, field positions and timing counts of the control tag decoder
`ifndef DTD_REGS_VH
`define DTD_REGS_VH

`define DTD_ADDR_CTRL         12'h000
`define DTD_ADDR_COND         12'h004
`define DTD_ADDR_ACTION       12'h008
`define DTD_ADDR_EVENT        12'h00C

`define DTD_CTRL_OFFSET_EN    0
`define DTD_CTRL_DUAL_EN      1
`define DTD_CTRL_RESET        32'h0000_0000

`define DTD_COND_FAULT        0
`define DTD_COND_SEEK_ERR     1
`define DTD_COND_WPROT        2
`define DTD_COND_RESET        32'h0000_0000

`define DTD_BIT_WRITE         0
`define DTD_BIT_READ          1
`define DTD_BIT_OFS_IN        2
`define DTD_BIT_OFS_OUT       3
`define DTD_BIT_FCLR          4
`define DTD_BIT_AMARK         5
`define DTD_BIT_HOME          6
`define DTD_BIT_EARLY         7
`define DTD_BIT_LATE          8
`define DTD_BIT_RELEASE       9

`define DTD_SETTLE_US_X100    275
`define DTD_CLK_MHZ           100
`define DTD_SETTLE_CYCLES     (`DTD_SETTLE_US_X100 * 10 * `DTD_CLK_MHZ / 1)

`endif

// ===== tb/dtd_ctrl_model.sv
// Controller side of the control cable: pick, command tag and bus bits
`timescale 1ns/100ps
module dtd_ctrl_model (
    input  wire logic       hclk,
    input  wire logic       pick_req,
    input  wire logic       tag_req,
    input  wire logic [9:0] bits_req,
    output logic            drive_pick,
    output logic            cmd_tag,
    output logic      [9:0] bus_bits
);
    initial begin
        drive_pick = 1'b0;
        cmd_tag = 1'b0;
        bus_bits = 10'h000;
    end
    always @(posedge hclk) begin
        drive_pick <= pick_req;
        cmd_tag    <= tag_req;
        // Outside the tag the lines mean nothing, so they wander
        bus_bits   <= tag_req ? bits_req : ~bus_bits;
    end
endmodule

// ===== tb/dtd_properties.sv
// Concurrent checks on the cable outputs of the tag decoder
`timescale 1ns/100ps
module dtd_properties #(
    parameter SETTLE_CYCLES = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic drive_pick,
    input wire logic fault_cause,
    input wire logic seek_err_set,
    input wire logic write_enable,
    input wire logic read_enable,
    input wire logic read_sync_start,
    input wire logic offset_in,
    input wire logic offset_out,
    input wire logic track_settled,
    input wire logic fault,
    input wire logic seek_error,
    input wire logic home_seek,
    input wire logic strobe_early,
    input wire logic strobe_late,
    input wire logic release_reserve,
    input wire logic channel_reserved,
    input wire logic priority_reserved
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_fault_blocks_write: assert property (fault && $past(fault) |-> !write_enable)
        else $error("write enabled while fault latched");
    chk_read_refused: assert property ($past(fault || seek_error) && (fault || seek_error) |-> !read_enable)
        else $error("read enabled during error");
    chk_no_pick_quiet: assert property (!drive_pick [*8] |-> !write_enable && !read_enable && !track_settled)
        else $error("output driven while not picked");
    chk_sync_with_read: assert property (read_sync_start |-> ##[0:1] read_enable)
        else $error("read sync start without read enable");
    chk_home_pulse: assert property (home_seek |=> !home_seek)
        else $error("home seek longer than one cycle");
    chk_home_clears_seek: assert property (home_seek && !seek_err_set && !$past(seek_err_set) |=> !seek_error)
        else $error("seek error kept after home seek");
    chk_settle_hold: assert property ($rose(offset_in) || $rose(offset_out) |-> ##2 !track_settled [*8])
        else $error("track settled too soon after offset");
    chk_strobe_exclusive: assert property (!(strobe_early && strobe_late))
        else $error("early and late strobe together");
    chk_offset_exclusive: assert property (!(offset_in && offset_out))
        else $error("both offsets together");
    chk_fault_clear_cause: assert property ($fell(fault) |-> !$past(fault_cause))
        else $error("fault cleared while cause present");
    chk_release_drops: assert property (release_reserve |-> !channel_reserved && !priority_reserved)
        else $error("reserve kept during release");
endmodule
bind dtd_decoder dtd_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_dtd_properties (
    .hclk(hclk), .hresetn(hresetn), .drive_pick(drive_pick), .fault_cause(fault_cause),
    .seek_err_set(seek_err_set), .write_enable(write_enable), .read_enable(read_enable),
    .read_sync_start(read_sync_start), .offset_in(offset_in), .offset_out(offset_out),
    .track_settled(track_settled), .fault(fault), .seek_error(seek_error), .home_seek(home_seek),
    .strobe_early(strobe_early), .strobe_late(strobe_late), .release_reserve(release_reserve),
    .channel_reserved(channel_reserved), .priority_reserved(priority_reserved));

// ===== tb/tb_disk_drive_control_tag_decoder.sv
// Testbench for the control tag decoder
`timescale 1ns/100ps
module tb_disk_drive_control_tag_decoder;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        pick_req = 1'b0, tag_req = 1'b0, fault_cause = 1'b0, seek_err_set = 1'b0, cres = 1'b0, pres = 1'b0;
    logic [9:0]  bits_req = 10'h000;
    wire  [31:0] hrdata;
    wire  [9:0]  bus_bits;
    wire         hreadyout, hresp, drive_pick, cmd_tag, write_enable, read_enable, read_sync_start, offset_in;
    wire         offset_out, track_settled, fault, seek_error, amark_write, amark_search, home_seek, home_reset;
    wire         strobe_early, strobe_late, release_reserve, channel_reserved, priority_reserved;
    int          n_fail = 0, compares = 0;
    int          lv_bit[4] = '{7, 8, 2, 3};
    logic [4:0]  lv_exp[4] = '{5'h12, 5'h11, 5'h08, 5'h04};
    int          n_home = 0, n_hreset = 0, n_rel = 0, n_rsync = 0;
    wire   [4:0] lv_seen = {track_settled, offset_in, offset_out, strobe_early, strobe_late};
    always #5 hclk = ~hclk;
    // Pulse outputs stand for one cycle only, so each edge counts them
    always @(posedge hclk) begin
        n_home   <= n_home + (home_seek === 1'b1);
        n_hreset <= n_hreset + (home_reset === 1'b1);
        n_rel    <= n_rel + (release_reserve === 1'b1);
        n_rsync  <= n_rsync + (read_sync_start === 1'b1);
    end
    dtd_ctrl_model u_dtd_ctrl_model (.hclk(hclk), .pick_req(pick_req), .tag_req(tag_req), .bits_req(bits_req),
        .drive_pick(drive_pick), .cmd_tag(cmd_tag), .bus_bits(bus_bits));
    dtd_decoder #(.SETTLE_CYCLES(20)) u_dtd_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .drive_pick(drive_pick), .cmd_tag(cmd_tag), .bus_bits(bus_bits),
        .fault_cause(fault_cause), .seek_err_set(seek_err_set), .channel_reserved_in(cres),
        .priority_reserved_in(pres), .write_enable(write_enable), .read_enable(read_enable),
        .read_sync_start(read_sync_start), .offset_in(offset_in), .offset_out(offset_out),
        .track_settled(track_settled), .fault(fault), .seek_error(seek_error), .amark_write(amark_write),
        .amark_search(amark_search), .home_seek(home_seek), .home_reset(home_reset),
        .strobe_early(strobe_early), .strobe_late(strobe_late), .release_reserve(release_reserve),
        .channel_reserved(channel_reserved), .priority_reserved(priority_reserved));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic cmd(input logic [9:0] b);
        tag_req <= 1'b1;
        bits_req <= b;
        repeat (10) @(posedge hclk);
    endtask
    task automatic idle;
        tag_req <= 1'b0;
        repeat (10) @(posedge hclk);
    endtask
    task automatic final_report;
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge hclk);
        n_fail++;
        final_report();
    end
    initial begin
        logic [31:0] rd;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("hreadyout", 1'h1, hreadyout);
        chk("hresp", 1'h0, hresp);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        chk("ctrl reset", 32'h0000_0000, rd);
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
        chk("unmapped", 32'h0000_0000, rd);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0003, rd);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        chk("ctrl", 32'h0000_0003, rd);
        cmd(10'h001);
        chk("write_enable unpicked", 1'h0, write_enable);
        idle();
        pick_req <= 1'b1;
        cmd(10'h021);
        chk("write_enable", 1'h1, write_enable);
        chk("amark_write", 1'h1, amark_write);
        idle();
        chk("write_enable dropped", 1'h0, write_enable);
        cmd(10'h022);
        chk("read_enable", 1'h1, read_enable);
        chk("amark_search", 1'h1, amark_search);
        idle();
        for (int i = 0; i < 4; i++) begin
            cmd(10'h001 << lv_bit[i]);
            chk("levels", lv_exp[i], lv_seen);
            idle();
        end
        repeat (30) @(posedge hclk);
        chk("track_settled", 1'h1, track_settled);
        fault_cause <= 1'b1;
        cmd(10'h003);
        chk("fault", 1'h1, fault);
        chk("write_enable fault", 1'h0, write_enable);
        chk("read_enable fault", 1'h0, read_enable);
        idle();
        cmd(10'h010);
        idle();
        chk("fault kept", 1'h1, fault);
        fault_cause <= 1'b0;
        cmd(10'h010);
        idle();
        chk("fault cleared", 1'h0, fault);
        seek_err_set <= 1'b1;
        @(posedge hclk);
        seek_err_set <= 1'b0;
        cmd(10'h002);
        chk("seek_error", 1'h1, seek_error);
        chk("read_enable seek", 1'h0, read_enable);
        idle();
        cmd(10'h040);
        idle();
        chk("seek_error home", 1'h0, seek_error);
        cres <= 1'b1;
        pres <= 1'b1;
        cmd(10'h200);
        idle();
        chk("channel_reserved", 1'h1, channel_reserved);
        chk("priority_reserved", 1'h1, priority_reserved);
        ahb(1'b1, 32'h0000_0004, 32'h0000_0004, rd);
        cmd(10'h001);
        chk("write_enable protected", 1'h0, write_enable);
        idle();
        // Offsets and release are refused once the unit lacks both options
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000, rd);
        cmd(10'h204);
        chk("offset_in unsupported", 1'h0, offset_in);
        chk("track_settled unsupported", 1'h1, track_settled);
        idle();
        chk("release pulses", 32'h0000_0001, n_rel);
        chk("home_seek pulses", 32'h0000_0001, n_home);
        chk("home_reset pulses", 32'h0000_0001, n_hreset);
        chk("read_sync_start pulses", 32'h0000_0001, n_rsync);
        ahb(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        chk("tag rises", 32'h0000_000E, rd);
        final_report();
    end
endmodule
